/* File: hw/cse_top.sv */
/*
  Status word, exception ranking, vector selection and entry, and gating of
  system control coprocessor accesses, with an APB register slave.
  Assumes request inputs come from logic on pclk; only the vector strap is
  asynchronous and is synchronised here.
*/
// The implementer's own choices: the APB interface to the registers and the register addresses.
// How it works
// - Status bit 7 set blocks normal interrupts; clear lets them in.
// - Status bit 6 set blocks fast interrupts; clear lets them in.
// - Status bit 5 selects compact instruction state when one, full when zero.
// - Mode field bits 4:0 decode to user, fast, normal, supervisor, abort, undefined, system.
// - Bits 27:8 are reserved, low byte is control, top nibble is flags.
// - Flags follow the latest arithmetic result: N31, Z30, C29, V28.
// - Ranking: reset, data abort, fast, normal, prefetch abort, undefined or trap.
// - Trap and undefined share the lowest level; the code ranks undefined above trap.
// - Vector base is zero or FFFF0000 by the high vector select.
// - Vector offsets 0,4,8,C,10,18,1C; offset 14 unused.
// - Reset enters supervisor, fast enters fast mode; both masks set.
// - Other exceptions enter their mode, set normal mask, keep fast mask.
// - Failed memory accesses raise prefetch or data abort.
// - Undefined encodings raise the undefined exception.
// - Coprocessor accesses reach the control coprocessor only in privileged modes.
// - Active stack pointer bank follows the current mode.
// - Privileged modes are entered only from privileged modes or by taking an exception.
`timescale 1ns/1ps
`default_nettype none
module cse_top
  import cse_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Exception sources
  input  wire logic              normal_irq_req,
  input  wire logic              fast_interrupt_req,
  input  wire logic              prefetch_abort,
  input  wire logic              data_abort,
  input  wire logic              undef_instr,
  input  wire logic              software_trap,
  input  wire logic [31:0]       exc_ret_addr,
  input  wire logic              high_vector_select,
  // Arithmetic flags
  input  wire logic              alu_flags_valid,
  input  wire logic [FLAG_W-1:0] alu_flags,
  // Coprocessor access
  input  wire logic              cop_access_req,
  output logic                   cop_access_grant,
  output logic                   cop_access_fault,
  // Entry and state
  output logic                   exc_ack,
  output cse_exc_t               exc_ack_kind,
  output logic                   exc_entry,
  output logic      [31:0]       exc_vector,
  output logic      [31:0]       status_word,
  output logic                   compact_instruction_set,
  output logic      [2:0]        banked_stack_pointer
);

  // ==========================================================
  // State
  logic [31:0] stw_ff;
  logic        rst_pend_ff;
  logic        pabt_ff, dabt_ff, und_ff, trap_ff;
  logic        hv_meta_ff, hv_sync_ff;
  logic [31:0] vec_ff;
  logic        entry_ff;
  logic [2:0]  sp_ff;
  cse_exc_t    last_ff;
  logic [31:0] prdata_ff;
  logic [31:0] bank_stw_ff [0:BANKS-1];
  logic [31:0] bank_ret_ff [0:BANKS-1];

  function automatic logic [2:0] cse_bank(input logic [4:0] m);
    case (m)
      MODE_FIQ: cse_bank = BANK_FIQ;
      MODE_IRQ: cse_bank = BANK_IRQ;
      MODE_SVC: cse_bank = BANK_SVC;
      MODE_ABT: cse_bank = BANK_ABT;
      MODE_UND: cse_bank = BANK_UND;
      default:  cse_bank = BANK_USR;
    endcase
  endfunction

  // ==========================================================
  // Ranking
  wire [4:0] mode_cur = stw_ff[MODE_LSB +: MODE_W];
  wire       priv     = (mode_cur != MODE_USR);
  wire       cop_flt  = cop_access_req & ~priv;
  wire       dabt_p   = dabt_ff | data_abort;
  wire       pabt_p   = pabt_ff | prefetch_abort;
  wire       und_p    = und_ff | undef_instr | cop_flt;
  wire       trap_p   = trap_ff | software_trap;
  wire       fiq_ok   = fast_interrupt_req & ~stw_ff[FIQ_MASK_BIT];
  wire       irq_ok   = normal_irq_req & ~stw_ff[IRQ_MASK_BIT];
  // Undefined and trap can be pending at once; undefined is then taken first, trap after
  wire cse_exc_t sel =
      rst_pend_ff ? CSE_EXC_RST  :
      dabt_p      ? CSE_EXC_DABT :
      fiq_ok      ? CSE_EXC_FIQ  :
      irq_ok      ? CSE_EXC_IRQ  :
      pabt_p      ? CSE_EXC_PABT :
      und_p       ? CSE_EXC_UND  :
      trap_p      ? CSE_EXC_TRAP : CSE_EXC_NONE;
  wire take = (sel != CSE_EXC_NONE);

  // A pulse taken through the bypass is not latched a second time, so one
  // event gives one entry; a new pulse behind an older one stays (set wins)
  wire und_ev   = undef_instr | cop_flt;
  wire nxt_dabt = (dabt_p & (sel != CSE_EXC_DABT)) | (dabt_ff & data_abort);
  wire nxt_pabt = (pabt_p & (sel != CSE_EXC_PABT)) | (pabt_ff & prefetch_abort);
  wire nxt_und  = (und_p & (sel != CSE_EXC_UND)) | (und_ff & und_ev);
  wire nxt_trap = (trap_p & (sel != CSE_EXC_TRAP)) | (trap_ff & software_trap);

  wire [31:0] vec_off =
      (sel == CSE_EXC_RST)  ? VEC_RST  :
      (sel == CSE_EXC_UND)  ? VEC_UND  :
      (sel == CSE_EXC_TRAP) ? VEC_TRAP :
      (sel == CSE_EXC_PABT) ? VEC_PABT :
      (sel == CSE_EXC_DABT) ? VEC_DABT :
      (sel == CSE_EXC_IRQ)  ? VEC_IRQ  : VEC_FIQ;
  wire [31:0] vec_base = hv_sync_ff ? VEC_BASE_HI : VEC_BASE_LO;

  wire [4:0] mode_new =
      (sel == CSE_EXC_RST || sel == CSE_EXC_TRAP) ? MODE_SVC :
      (sel == CSE_EXC_FIQ)  ? MODE_FIQ :
      (sel == CSE_EXC_IRQ)  ? MODE_IRQ :
      (sel == CSE_EXC_UND)  ? MODE_UND : MODE_ABT;
  wire fmask_new = (sel == CSE_EXC_RST || sel == CSE_EXC_FIQ) | stw_ff[FIQ_MASK_BIT];

  // ==========================================================
  // Status word update: software, then flags, then entry on top
  wire        apb_acc  = psel & penable;
  wire        wr_stw   = apb_acc & pwrite & (paddr == REG_STW);
  // User writes keep the low byte, which also bars entry to privileged modes
  wire [31:0] sw_val   = priv ? (pwdata & ~RSVD_MASK)
                              : {pwdata[31:FLAG_LSB], stw_ff[FLAG_LSB-1:0]};
  wire [31:0] stw_a    = wr_stw ? sw_val : stw_ff;
  wire [31:0] stw_b    = alu_flags_valid ? {alu_flags, stw_a[FLAG_LSB-1:0]} : stw_a;
  // Entry returns to the full instruction state
  wire [31:0] stw_e    = {stw_b[31:8], 1'b1, fmask_new, 1'b0, mode_new};
  wire [31:0] nxt_stw  = take ? stw_e : stw_b;
  wire [2:0]  bank_new = cse_bank(mode_new);
  wire [2:0]  bank_cur = cse_bank(mode_cur);
  wire        cur_bk   = (bank_cur != BANK_USR);

  // ==========================================================
  // APB read mux
  wire [31:0] saved_cur = cur_bk ? bank_stw_ff[bank_cur] : 32'h00000000;
  wire [31:0] ret_cur   = cur_bk ? bank_ret_ff[bank_cur] : 32'h00000000;
  wire        hit       = (paddr == REG_STW) | (paddr == REG_SAVED) |
                          (paddr == REG_RET) | (paddr == REG_INFO);
  wire [31:0] rd_mux    =
      (paddr == REG_STW)   ? stw_ff :
      (paddr == REG_SAVED) ? saved_cur :
      (paddr == REG_RET)   ? ret_cur :
      (paddr == REG_INFO)  ? {28'h0000000, hv_sync_ff, 3'(last_ff)} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hv_meta_ff <= 1'b0;
      hv_sync_ff <= 1'b0;
    end else begin
      hv_meta_ff <= high_vector_select;
      hv_sync_ff <= hv_meta_ff;
    end
  end

  // Latched sources: a new event in the cycle of its take stays pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_pend_ff <= 1'b1;
      pabt_ff     <= 1'b0;
      dabt_ff     <= 1'b0;
      und_ff      <= 1'b0;
      trap_ff     <= 1'b0;
    end else begin
      rst_pend_ff <= 1'b0;
      dabt_ff     <= nxt_dabt;
      pabt_ff     <= nxt_pabt;
      und_ff      <= nxt_und;
      trap_ff     <= nxt_trap;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stw_ff    <= STW_RESET;
      vec_ff    <= VEC_BASE_LO;
      entry_ff  <= 1'b0;
      sp_ff     <= BANK_SVC;
      last_ff   <= CSE_EXC_NONE;
      prdata_ff <= 32'h00000000;
    end else begin
      stw_ff    <= nxt_stw;
      entry_ff  <= take;
      sp_ff     <= cse_bank(nxt_stw[MODE_LSB +: MODE_W]);
      if (take) begin
        vec_ff  <= vec_base | vec_off;
        last_ff <= sel;
      end
      if (psel && !penable) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < BANKS; i++) begin
        bank_stw_ff[i] <= 32'h00000000;
        bank_ret_ff[i] <= 32'h00000000;
      end
    end else if (take) begin
      bank_stw_ff[bank_new] <= stw_ff;
      bank_ret_ff[bank_new] <= exc_ret_addr;
    end
  end

  // ==========================================================
  // Outputs
  assign prdata                  = prdata_ff;
  assign pready                  = 1'b1;
  assign pslverr                 = apb_acc & ~hit;
  assign cop_access_grant        = cop_access_req & priv;
  assign cop_access_fault        = cop_flt;
  assign exc_ack                 = take;
  assign exc_ack_kind            = sel;
  assign exc_entry               = entry_ff;
  assign exc_vector              = vec_ff;
  assign status_word             = stw_ff;
  assign compact_instruction_set = stw_ff[STATE_BIT];
  assign banked_stack_pointer    = sp_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  irq_block_a: assert property (exc_ack && exc_ack_kind == CSE_EXC_IRQ
    |-> !status_word[IRQ_MASK_BIT]) else $error("masked normal irq taken");
  fiq_block_a: assert property (exc_ack && exc_ack_kind == CSE_EXC_FIQ
    |-> !status_word[FIQ_MASK_BIT]) else $error("masked fast irq taken");
  dabt_rank_a: assert property (!rst_pend_ff && data_abort
    |-> exc_ack_kind == CSE_EXC_DABT) else $error("data abort outranked");
  vector_sel_a: assert property (exc_ack && exc_ack_kind == CSE_EXC_IRQ && !hv_sync_ff
    |=> exc_entry && exc_vector == 32'h00000018) else $error("bad irq vector");
  fiq_entry_a: assert property (exc_ack && exc_ack_kind == CSE_EXC_FIQ
    |=> status_word[4:0] == MODE_FIQ && status_word[7:6] == 2'b11)
    else $error("bad fast entry");
  fmask_keep_a: assert property (exc_ack && exc_ack_kind == CSE_EXC_IRQ
    |=> status_word[FIQ_MASK_BIT] == $past(status_word[FIQ_MASK_BIT]) &&
        status_word[IRQ_MASK_BIT]) else $error("irq entry masks wrong");
  user_write_a: assert property (wr_stw && !priv && !exc_ack
    |=> status_word[27:0] == $past(status_word[27:0])) else $error("user changed control");
  cop_gate_a: assert property (cop_access_grant |-> status_word[4:0] != MODE_USR)
    else $error("user reached coprocessor");
  save_word_a: assert property (exc_ack |=> saved_cur == $past(status_word))
    else $error("status not saved");
  sp_follow_a: assert property (##1 banked_stack_pointer == cse_bank(status_word[4:0]))
    else $error("stack bank stale");

  rst_take_c: cover property (exc_ack && exc_ack_kind == CSE_EXC_RST);
  fiq_over_irq_c: cover property (fast_interrupt_req && normal_irq_req && exc_ack
    && exc_ack_kind == CSE_EXC_FIQ);
  cop_fault_c: cover property (cop_access_fault && exc_ack && exc_ack_kind == CSE_EXC_UND);

endmodule // cse_top
`default_nettype wire

/* File: hw/cse_pkg.sv */
/*
  Constants and types of the status word and exception entry block.
  Assumes nothing of its surroundings; imported by the block's top module.
*/
package cse_pkg;

  // ==========================================================
  // Status word layout
  localparam int          STW_W        = 32;
  localparam int          IRQ_MASK_BIT = 7;
  localparam int          FIQ_MASK_BIT = 6;
  localparam int          STATE_BIT    = 5;
  localparam int          MODE_LSB     = 0;
  localparam int          MODE_W       = 5;
  localparam int          FLAG_LSB     = 28;
  localparam int          FLAG_W       = 4;
  localparam logic [31:0] RSVD_MASK    = 32'h0fffff00;
  localparam logic [31:0] STW_RESET    = 32'h000000d3;

  // ==========================================================
  // Mode codes
  localparam logic [4:0] MODE_USR = 5'h10;
  localparam logic [4:0] MODE_FIQ = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_ABT = 5'h17;
  localparam logic [4:0] MODE_UND = 5'h1b;
  localparam logic [4:0] MODE_SYS = 5'h1f;

  // ==========================================================
  // Banks: one saved word per exception mode, user and system share none
  localparam int         BANKS    = 5;
  localparam logic [2:0] BANK_FIQ = 3'h0;
  localparam logic [2:0] BANK_IRQ = 3'h1;
  localparam logic [2:0] BANK_SVC = 3'h2;
  localparam logic [2:0] BANK_ABT = 3'h3;
  localparam logic [2:0] BANK_UND = 3'h4;
  localparam logic [2:0] BANK_USR = 3'h5;

  // ==========================================================
  // Vector table
  localparam logic [31:0] VEC_BASE_LO = 32'h00000000;
  localparam logic [31:0] VEC_BASE_HI = 32'hffff0000;
  localparam logic [31:0] VEC_RST     = 32'h00000000;
  localparam logic [31:0] VEC_UND     = 32'h00000004;
  localparam logic [31:0] VEC_TRAP    = 32'h00000008;
  localparam logic [31:0] VEC_PABT    = 32'h0000000c;
  localparam logic [31:0] VEC_DABT    = 32'h00000010;
  localparam logic [31:0] VEC_RSVD    = 32'h00000014;
  localparam logic [31:0] VEC_IRQ     = 32'h00000018;
  localparam logic [31:0] VEC_FIQ     = 32'h0000001c;

  // ==========================================================
  // Register offsets
  localparam int         ADDR_W    = 8;
  localparam logic [7:0] REG_STW   = 8'h00;
  localparam logic [7:0] REG_SAVED = 8'h04;
  localparam logic [7:0] REG_RET   = 8'h08;
  localparam logic [7:0] REG_INFO  = 8'h0c;

  typedef enum logic [2:0] {
    CSE_EXC_NONE, CSE_EXC_RST, CSE_EXC_DABT, CSE_EXC_FIQ,
    CSE_EXC_IRQ, CSE_EXC_PABT, CSE_EXC_UND, CSE_EXC_TRAP
  } cse_exc_t;

endpackage

/* File: tb/cse_src_model.sv */
/*
  Model of the interrupt controller and memory pipeline feeding the block.
  Assumes the bench pulses fire for one cycle with the sources to raise.
*/
`timescale 1ns/1ps
`default_nettype none
module cse_src_model
  import cse_pkg::*;
(
  // Clock, reset and bench command; what = {irq, fiq, pabt, dabt, und, trap}
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       fire,
  input  wire logic [5:0] what,
  // Taken exception
  input  wire logic       exc_ack,
  input  wire cse_exc_t   exc_ack_kind,
  // Requests into the block
  output logic            normal_irq_req,
  output logic            fast_interrupt_req,
  output logic            prefetch_abort,
  output logic            data_abort,
  output logic            undef_instr,
  output logic            software_trap
);
  // ==========================================================
  // Interrupt levels hold until taken, as a real controller would
  wire logic take_irq = exc_ack && (exc_ack_kind == CSE_EXC_IRQ);
  wire logic take_fiq = exc_ack && (exc_ack_kind == CSE_EXC_FIQ);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      normal_irq_req     <= 1'b0;
      fast_interrupt_req <= 1'b0;
      {prefetch_abort, data_abort, undef_instr, software_trap} <= 4'h0;
    end else begin
      normal_irq_req     <= (fire && what[5]) || (normal_irq_req && !take_irq);
      fast_interrupt_req <= (fire && what[4]) || (fast_interrupt_req && !take_fiq);
      // Faults last one cycle; the block must latch them
      {prefetch_abort, data_abort, undef_instr, software_trap} <= fire ? what[3:0] : 4'h0;
    end
  end
endmodule // cse_src_model
`default_nettype wire

/* File: tb/testbench.sv */
/*
  Self-checking bench: APB register tasks and exception sequences.
  Assumes the source model above and an APB slave on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cse_pkg::*;
;
  // ==========================================================
  // Signals
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata, exc_vector, status_word, rd_data;
  logic              pready, pslverr, rd_err, exc_ack, exc_entry, compact_instruction_set;
  logic              cop_access_grant, cop_access_fault, fp;
  logic              normal_irq_req, fast_interrupt_req, prefetch_abort;
  logic              data_abort, undef_instr, software_trap;
  logic [31:0]       exc_ret_addr = 32'h00000100;
  logic              high_vector_select = 1'b0;
  logic              alu_flags_valid = 1'b0;
  logic [3:0]        alu_flags = 4'h0;
  logic              cop_access_req = 1'b0;
  logic              fire = 1'b0;
  logic [5:0]        what = 6'h00;
  cse_exc_t          exc_ack_kind, lk;
  logic [2:0]        banked_stack_pointer;
  logic [23:0]       seen = '0;
  logic [39:0]       e;
  int                fail_count = 0;
  int                checks_done = 0;
  int                cyc = 0;

  always #20 pclk = ~pclk;

  cse_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .normal_irq_req, .fast_interrupt_req, .prefetch_abort,
    .data_abort, .undef_instr, .software_trap, .exc_ret_addr, .high_vector_select,
    .alu_flags_valid, .alu_flags, .cop_access_req, .cop_access_grant, .cop_access_fault,
    .exc_ack, .exc_ack_kind, .exc_entry, .exc_vector, .status_word,
    .compact_instruction_set, .banked_stack_pointer);

  cse_src_model src (.pclk, .presetn, .fire, .what, .exc_ack, .exc_ack_kind,
    .normal_irq_req, .fast_interrupt_req, .prefetch_abort, .data_abort,
    .undef_instr, .software_trap);

  // ==========================================================
  // Helpers
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request holds until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic go(input logic [5:0] w, input int n);
    @(negedge pclk);
    seen = '0;
    @(posedge pclk);
    fire <= 1'b1;
    what <= w;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask

  function automatic logic [39:0] ent(input cse_exc_t k);
    case (k)
      CSE_EXC_RST:  ent = {VEC_RST, MODE_SVC, BANK_SVC};
      CSE_EXC_DABT: ent = {VEC_DABT, MODE_ABT, BANK_ABT};
      CSE_EXC_FIQ:  ent = {VEC_FIQ, MODE_FIQ, BANK_FIQ};
      CSE_EXC_IRQ:  ent = {VEC_IRQ, MODE_IRQ, BANK_IRQ};
      CSE_EXC_PABT: ent = {VEC_PABT, MODE_ABT, BANK_ABT};
      CSE_EXC_UND:  ent = {VEC_UND, MODE_UND, BANK_UND};
      default:      ent = {VEC_TRAP, MODE_SVC, BANK_SVC};
    endcase
  endfunction

  // ==========================================================
  // Entry monitor: every taken exception is judged here
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      complete_run();
    end
    if (presetn === 1'b1 && exc_entry === 1'b1) begin
      e = ent(lk);
      chk(exc_vector, (high_vector_select ? VEC_BASE_HI : VEC_BASE_LO) + e[39:8]);
      chk(32'(status_word[7:0]), {24'h0, 1'b1, (lk == CSE_EXC_RST || lk == CSE_EXC_FIQ) | fp,
        1'b0, e[7:3]});
      chk(32'(banked_stack_pointer), 32'(e[2:0]));
    end
    if (presetn === 1'b1 && exc_ack === 1'b1) begin
      seen <= {seen[20:0], exc_ack_kind};
      lk <= exc_ack_kind;
      fp <= status_word[6];
    end
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(32'(seen), 32'(CSE_EXC_RST));
    apb(1'b0, REG_STW, 32'h0);
    chk(rd_data, STW_RESET);
    apb(1'b0, 8'h10, 32'h0);
    chk(32'(rd_err), 32'h1);
    apb(1'b1, REG_STW, 32'hffffff13);
    apb(1'b0, REG_STW, 32'h0);
    chk(rd_data, 32'hf0000013);
    $display("test registers done");
    go(6'h3f, 12);
    chk(32'(seen), 32'({CSE_EXC_DABT, CSE_EXC_FIQ, CSE_EXC_PABT, CSE_EXC_UND, CSE_EXC_TRAP}));
    apb(1'b1, REG_STW, 32'h13);
    repeat (4) @(posedge pclk);
    chk(32'(seen[5:0]), 32'({CSE_EXC_TRAP, CSE_EXC_IRQ}));
    apb(1'b1, REG_STW, 32'h53);
    go(6'h30, 10);
    chk(32'(seen), 32'(CSE_EXC_IRQ));
    apb(1'b1, REG_STW, 32'h13);
    repeat (4) @(posedge pclk);
    chk(32'(seen), 32'({CSE_EXC_IRQ, CSE_EXC_FIQ}));
    $display("test ranking done");
    alu_flags_valid <= 1'b1;
    alu_flags <= 4'h5;
    @(posedge pclk);
    alu_flags_valid <= 1'b0;
    @(negedge pclk);
    chk(32'(status_word[31:28]), 32'h5);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, REG_STW, 32'h13 | (i << 5));
      @(negedge pclk);
      chk(32'(compact_instruction_set), 32'(i));
    end
    high_vector_select <= 1'b1;
    repeat (5) @(posedge pclk);
    go(6'h01, 6);
    high_vector_select <= 1'b0;
    $display("test status done");
    apb(1'b1, REG_STW, 32'h000000d0);
    apb(1'b1, REG_STW, 32'hffffff1f);
    apb(1'b0, REG_STW, 32'h0);
    chk(rd_data, 32'hf00000d0);
    chk(32'(banked_stack_pointer), 32'(BANK_USR));
    for (int i = 0; i < 2; i++) begin
      @(negedge pclk);
      seen = '0;
      @(posedge pclk);
      cop_access_req <= 1'b1;
      @(negedge pclk);
      chk(32'({cop_access_grant, cop_access_fault}), 32'(i + 1));
      @(posedge pclk);
      cop_access_req <= 1'b0;
      repeat (5) @(posedge pclk);
      chk(32'(seen), 32'(i ? CSE_EXC_NONE : CSE_EXC_UND));
    end
    apb(1'b1, REG_STW, 32'h000000d0);
    go(6'h01, 6);
    chk(32'(seen), 32'(CSE_EXC_TRAP));
    apb(1'b0, REG_SAVED, 32'h0);
    chk(rd_data, 32'h000000d0);
    apb(1'b0, REG_RET, 32'h0);
    chk(rd_data, exc_ret_addr);
    apb(1'b0, REG_INFO, 32'h0);
    chk(rd_data, 32'(CSE_EXC_TRAP));
    $display("test user mode done");
    complete_run();
  end
endmodule // testbench
`default_nettype wire
